// >>> rtl/cpu_ttw_consts.vh
// Purpose: constants for the test/transfer/wait decode block
// Assumes: 8-bit core, 16-bit address space
// Notes:   included by cpu_test_transfer_wait_decode.v
// Functional notes
// - test op subtracts zero, sets negative and zero, keeps operand and half-carry
// - index-to-accumulator copy, opcode 9F, no flag changes
// - wait op 8F clears interrupt mask and stops the core clock in the same cycle
// - short-offset indexed: one byte, unsigned offset plus index
// - long-offset indexed: high then low byte, 16-bit offset plus index
// - full address mode: high then low byte used as address
// - bit branch: direct address byte then signed offset added to pc
`ifndef CPU_TTW_CONSTS_VH
`define CPU_TTW_CONSTS_VH
//--------------------------------------
// opcodes
//--------------------------------------
`define OP_TST_DIR   8'h3D
`define OP_TST_A     8'h4D
`define OP_TST_X     8'h5D
`define OP_TST_IX1   8'h6D
`define OP_TST_IX    8'h7D
`define OP_TXA       8'h9F
`define OP_WAIT      8'h8F
`define OP_BIT_HI    4'h0
`define OP_MODE_EXT  4'hC
`define OP_MODE_IX2  4'hD
`define OP_MODE_IX1  4'hE
`define ZERO8        8'h00
`define ZERO16       16'h0000
`define RESET_PC     16'h0000
`define PC_STEP      16'h0001
`define OFFSET_SIGN_BITS 4'h8
`endif

// >>> rtl/cpu_test_transfer_wait_decode.v
// Purpose: decode/execute of test, index transfer, wait and operand fetch modes
// Assumes: program byte at MEM_ADDR_O settles on MEM_DATA_I before the next edge
// Notes:   interrupt vector fetch is left to the core; this block flags it
`timescale 1ns/100ps
`include "cpu_ttw_consts.vh"
module cpu_test_transfer_wait_decode (
	input  wire        SYS_CLK_I,
	input  wire        RESET_I,
	input  wire [7:0]  MEM_DATA_I,
	input  wire [7:0]  OPERAND_I,
	input  wire        IRQ_PENDING_I,
	input  wire        BRANCH_TAKE_I,
	output reg  [15:0] MEM_ADDR_O,
	output reg  [15:0] EA_O,
	output reg         EA_VALID_O,
	output reg  [7:0]  ACC_O,
	output reg  [7:0]  INDEX_O,
	output reg         FLAG_N_O,
	output reg         FLAG_Z_O,
	output reg         FLAG_H_O,
	output reg         FLAG_I_O,
	output reg         CORE_CLK_EN_O,
	output reg         WAKE_VECTOR_O
);
	//--------------------------------------
	// one-hot states
	//--------------------------------------
	localparam S_FETCH = 6'b000001;
	localparam S_OP1   = 6'b000010;
	localparam S_OP2   = 6'b000100;
	localparam S_EXEC  = 6'b001000;
	localparam S_WAIT  = 6'b010000;
	localparam S_REL   = 6'b100000;

	reg [5:0]  state_r;
	reg [7:0]  opcode_r;
	reg [7:0]  hi_r;
	reg [15:0] pc_r;

	//--------------------------------------
	// decode helpers
	//--------------------------------------
	// test-op flag update; operand itself untouched
	function [1:0] nz_of;
		input [7:0] v;
		reg   [7:0] d;
		begin
			d     = v - `ZERO8;
			nz_of = {d[7], d == `ZERO8};
		end
	endfunction

	// bit-test-and-branch group: direct byte then relative offset
	function is_bit_branch;
		input [7:0] op;
		begin
			is_bit_branch = (op[7:4] == `OP_BIT_HI);
		end
	endfunction

	// operand byte is a direct-page address (direct-mode memory test 3D or bit branch)
	function is_direct_byte;
		input [7:0] op;
		begin
			is_direct_byte = (op == `OP_TST_DIR) || is_bit_branch(op);
		end
	endfunction

	// one unsigned offset byte added to the index register
	function is_short_index;
		input [7:0] op;
		begin
			is_short_index = (op == `OP_TST_IX1) || (op[7:4] == `OP_MODE_IX1);
		end
	endfunction

	// two offset bytes, high first, added to the index register
	function is_long_index;
		input [7:0] op;
		begin
			is_long_index = (op[7:4] == `OP_MODE_IX2);
		end
	endfunction

	// two address bytes, high first, used as the operand address
	function is_full_address;
		input [7:0] op;
		begin
			is_full_address = (op[7:4] == `OP_MODE_EXT);
		end
	endfunction

	// any opcode that fetches operand bytes after itself
	function needs_operand;
		input [7:0] op;
		begin
			needs_operand = is_direct_byte(op) || is_short_index(op)
				|| is_long_index(op) || is_full_address(op);
		end
	endfunction

	// memory forms of the test op: flags from the fetched data byte
	function is_mem_test;
		input [7:0] op;
		begin
			is_mem_test = (op == `OP_TST_DIR) || (op == `OP_TST_IX1) || (op == `OP_TST_IX);
		end
	endfunction

	//--------------------------------------
	// program counter arithmetic
	//--------------------------------------
	// address of the byte after the current one
	wire [15:0] pc_inc        = pc_r + `PC_STEP;
	// relative target: address past the offset byte plus signed offset
	wire [15:0] branch_target = pc_inc + {{`OFFSET_SIGN_BITS{MEM_DATA_I[7]}}, MEM_DATA_I};

	//--------------------------------------
	// sequencer
	//--------------------------------------
	always @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			state_r       <= S_FETCH;
			opcode_r      <= `ZERO8;
			hi_r          <= `ZERO8;
			pc_r          <= `RESET_PC;
			MEM_ADDR_O    <= `RESET_PC;
			EA_O          <= `ZERO16;
			EA_VALID_O    <= 1'b0;
			ACC_O         <= `ZERO8;
			INDEX_O       <= `ZERO8;
			FLAG_N_O      <= 1'b0;
			FLAG_Z_O      <= 1'b0;
			FLAG_H_O      <= 1'b0;
			FLAG_I_O      <= 1'b1;
			CORE_CLK_EN_O <= 1'b1;
			WAKE_VECTOR_O <= 1'b0;
		end else begin
			EA_VALID_O    <= 1'b0;
			WAKE_VECTOR_O <= 1'b0;
			case (state_r)
			S_FETCH: begin
				// opcode byte stands at MEM_ADDR_O; step past it
				opcode_r   <= MEM_DATA_I;
				pc_r       <= pc_inc;
				MEM_ADDR_O <= pc_inc;
				case (MEM_DATA_I)
				`OP_TST_A: begin
					{FLAG_N_O, FLAG_Z_O} <= nz_of(ACC_O);
				end
				`OP_TST_X: begin
					{FLAG_N_O, FLAG_Z_O} <= nz_of(INDEX_O);
				end
				`OP_TST_IX: begin
					EA_O       <= {`ZERO8, INDEX_O};
					EA_VALID_O <= 1'b1;
					state_r    <= S_EXEC;
				end
				`OP_TXA: begin
					ACC_O <= INDEX_O;
				end
				`OP_WAIT: begin
					FLAG_I_O      <= 1'b0;
					CORE_CLK_EN_O <= 1'b0;
					state_r       <= S_WAIT;
				end
				default: begin
					// unlisted opcodes without operand bytes act as one-cycle no-ops
					if (needs_operand(MEM_DATA_I)) begin
						state_r <= S_OP1;
					end
				end
				endcase
			end
			S_OP1: begin
				// first operand byte: address, short offset or high byte
				pc_r       <= pc_inc;
				MEM_ADDR_O <= pc_inc;
				hi_r       <= MEM_DATA_I;
				if (is_direct_byte(opcode_r)) begin
					EA_O       <= {`ZERO8, MEM_DATA_I};
					EA_VALID_O <= 1'b1;
					state_r    <= is_bit_branch(opcode_r) ? S_REL : S_EXEC;
				end else if (is_short_index(opcode_r)) begin
					EA_O       <= {`ZERO8, MEM_DATA_I} + {`ZERO8, INDEX_O};
					EA_VALID_O <= 1'b1;
					state_r    <= S_EXEC;
				end else begin
					state_r <= S_OP2;
				end
			end
			S_OP2: begin
				// second operand byte is always the low half
				pc_r       <= pc_inc;
				MEM_ADDR_O <= pc_inc;
				if (is_long_index(opcode_r)) begin
					EA_O <= {hi_r, MEM_DATA_I} + {`ZERO8, INDEX_O};
				end else begin
					EA_O <= {hi_r, MEM_DATA_I};
				end
				EA_VALID_O <= 1'b1;
				state_r    <= S_EXEC;
			end
			S_REL: begin
				// signed offset byte stands at pc; target counts from the byte after it
				if (BRANCH_TAKE_I) begin
					pc_r       <= branch_target;
					MEM_ADDR_O <= branch_target;
				end else begin
					pc_r       <= pc_inc;
					MEM_ADDR_O <= pc_inc;
				end
				state_r <= S_FETCH;
			end
			S_EXEC: begin
				// memory test: flags only, operand not written back
				if (is_mem_test(opcode_r)) begin
					{FLAG_N_O, FLAG_Z_O} <= nz_of(OPERAND_I);
				end
				state_r <= S_FETCH;
			end
			S_WAIT: begin
				// halted until unmasked interrupt
				if (IRQ_PENDING_I && !FLAG_I_O) begin
					CORE_CLK_EN_O <= 1'b1;
					WAKE_VECTOR_O <= 1'b1;
					FLAG_I_O      <= 1'b1;
					state_r       <= S_FETCH;
				end
			end
			default: begin
				state_r <= S_FETCH;
			end
			endcase
		end
	end
endmodule

// >>> testbench/cpu_ttw_checker.sv
// Purpose: port checks  Assumes: sync reset  Notes: bound below
`timescale 1ns/100ps
module cpu_ttw_checker(
	input wire        SYS_CLK_I,
	input wire        RESET_I,
	input wire [7:0]  MEM_DATA_I,
	input wire        IRQ_PENDING_I,
	input wire [15:0] EA_O,
	input wire        EA_VALID_O,
	input wire [7:0]  ACC_O,
	input wire [7:0]  INDEX_O,
	input wire        FLAG_H_O,
	input wire        FLAG_I_O,
	input wire        CORE_CLK_EN_O,
	input wire        WAKE_VECTOR_O);
default clocking @(posedge SYS_CLK_I); endclocking
default disable iff (RESET_I);
a_h_fixed: assert property (!FLAG_H_O) else $error("half carry moved");
a_acc_index: assert property (ACC_O == INDEX_O) else $error("acc differs");
a_wait_mask: assert property ($fell(CORE_CLK_EN_O) |-> !FLAG_I_O) else $error("mask kept");
a_halt_hold: assert property (!CORE_CLK_EN_O && !IRQ_PENDING_I |=> !CORE_CLK_EN_O) else $error("woke");
a_wake_go: assert property (!CORE_CLK_EN_O && IRQ_PENDING_I |=> CORE_CLK_EN_O && WAKE_VECTOR_O && FLAG_I_O)
	else $error("no wake");
a_halt_still: assert property (!CORE_CLK_EN_O |=> $stable(ACC_O)) else $error("ran halted");
a_ea_pulse: assert property (EA_VALID_O |=> !EA_VALID_O) else $error("ea long");
a_ea_low: assert property (EA_VALID_O |-> EA_O[7:0] == $past(MEM_DATA_I) || EA_O == {8'h00, INDEX_O})
	else $error("ea byte");
endmodule
bind cpu_test_transfer_wait_decode cpu_ttw_checker u_cpu_ttw_checker(.SYS_CLK_I, .RESET_I, .MEM_DATA_I,
	.IRQ_PENDING_I, .EA_O, .EA_VALID_O, .ACC_O, .INDEX_O, .FLAG_H_O, .FLAG_I_O, .CORE_CLK_EN_O, .WAKE_VECTOR_O);

// >>> testbench/prog_mem.sv
// Purpose: program memory  Assumes: byte per address  Notes: idle bytes are no-ops
`timescale 1ns/100ps
module prog_mem(
	input  wire [15:0] addr_i,
	output wire [7:0]  data_o);
logic [7:0] mem [0:255];
// fill with an unlisted opcode
initial for (int k = 0; k < 256; k++) mem[k] = 8'h9D;
assign data_o = mem[addr_i[7:0]];
endmodule

// >>> testbench/testbench.sv
// Purpose: bench  Assumes: inputs move at falling edge  Notes: one reset per scenario
`timescale 1ns/100ps
module testbench;
logic clk = 0, rst = 1, irq = 0, take = 0;
logic [7:0] opnd = 8'h00;
wire [15:0] addr, ea;
wire [7:0] md, acc, idx;
wire eav, n, z, h, i, ce, wk;
int err_count = 0, check_count = 0, cyc = 0;
initial forever #2 clk = ~clk;
prog_mem u_prog_mem(.addr_i(addr), .data_o(md));
cpu_test_transfer_wait_decode u_cpu_test_transfer_wait_decode(.SYS_CLK_I(clk), .RESET_I(rst), .MEM_DATA_I(md),
	.OPERAND_I(opnd), .IRQ_PENDING_I(irq), .BRANCH_TAKE_I(take), .MEM_ADDR_O(addr), .EA_O(ea), .EA_VALID_O(eav),
	.ACC_O(acc), .INDEX_O(idx), .FLAG_N_O(n), .FLAG_Z_O(z), .FLAG_H_O(h), .FLAG_I_O(i), .CORE_CLK_EN_O(ce),
	.WAKE_VECTOR_O(wk));
// hang guard
always @(posedge clk) begin
	cyc <= cyc + 1;
	if (cyc == 2000) begin
		err_count++;
		test_done;
	end
end
task chk(input logic [15:0] a, input logic [15:0] b);
	check_count++;
	if (a !== b) begin
		err_count++;
		$display("CHECK FAILED %0t %h %h", $time, a, b);
	end
endtask
// load program, reset for 10 cycles
task rs(input logic [63:0] p);
	rst = 1;
	repeat (10) @(negedge clk);
	for (int k = 0; k < 8; k++) u_prog_mem.mem[k] = p[63-8*k -: 8];
	rst = 0;
endtask
task wea;
	for (int k = 0; k < 8 && eav !== 1'b1; k++) @(negedge clk);
endtask
task t_test;
	opnd = 8'h80;
	rs(64'h3D05_5D6D_104D_7D9D);
	wea;
	chk(ea, 16'h0005);
	@(negedge clk);
	chk({n, z, h}, 3'b100);
	@(negedge clk);
	chk({n, z, h}, 3'b010);
	wea;
	chk(ea, 16'h0010);
	@(negedge clk);
	chk({n, z, h}, 3'b100);
	@(negedge clk);
	chk({n, z, h}, 3'b010);
	opnd = 8'h01;
	wea;
	chk(ea, 16'h0000);
	@(negedge clk);
	chk({n, z, h}, 3'b000);
endtask
task t_modes;
	rs(64'hC612_34D6_ABCD_E67F);
	wea;
	chk(ea, 16'h1234);
	@(negedge clk);
	wea;
	chk(ea, 16'hABCD);
	@(negedge clk);
	wea;
	chk(ea, 16'h007F);
endtask
task t_branch;
	take = 1;
	rs(64'h0010_049D_9D9D_9D01);
	wea;
	chk(ea, 16'h0010);
	@(negedge clk);
	chk(addr, 16'h0007);
	take = 0;
	wea;
	chk(ea, 16'h009D);
	@(negedge clk);
	chk(addr, 16'h000A);
endtask
task t_wait;
	rs(64'h9F8F_9D9D_9D9D_9D9D);
	@(negedge clk);
	chk(acc, 16'h0000);
	@(negedge clk);
	chk({ce, i}, 2'b00);
	repeat (3) @(negedge clk);
	chk(ce, 1'b0);
	irq = 1;
	@(negedge clk);
	chk({ce, wk, i}, 3'b111);
	irq = 0;
endtask
task test_done;
	$display("errors %0d checks %0d", err_count, check_count);
	if (err_count == 0 && check_count > 0)
		$display("No errors found");
	else
		$display("Errors were found");
	$finish;
endtask
initial begin
	t_test;
	t_modes;
	t_branch;
	t_wait;
	test_done;
end
endmodule
